// *** verilog/ppfm_pkg.sv ***
// Purpose: Shared constants of the port pin function mux
// Assumes: 32-bit AXI4-Lite register bus, seven pins in compact slots
// Notes:   Slot k of every pin vector and register is one pin

package ppfm_pkg;

   // ----------------------------------------------------------------
   // Pin slots
   // ----------------------------------------------------------------
   localparam int NPIN  = 7;
   localparam int SEL_W = 3;
   localparam int AW    = 8;
   localparam int P_PA0 = 0;
   localparam int P_PA3 = 1;
   localparam int P_PB3 = 2;
   localparam int P_PB4 = 3;
   localparam int P_PB5 = 4;
   localparam int P_PB6 = 5;
   localparam int P_PB7 = 6;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] A_DATA = 8'h00;
   localparam logic [AW-1:0] A_DIR  = 8'h04;
   localparam logic [AW-1:0] A_PULL = 8'h08;
   localparam logic [AW-1:0] A_DIE  = 8'h0c;
   localparam logic [AW-1:0] A_WAKE = 8'h10;
   localparam logic [AW-1:0] A_IN   = 8'h14;
   localparam logic [AW-1:0] A_SEL  = 8'h18;
   localparam logic [AW-1:0] A_STAT = 8'h1c;
   localparam logic [AW-1:0] A_MASK = 8'h20;

   // ----------------------------------------------------------------
   // Reset values, fields, codes
   // ----------------------------------------------------------------
   localparam logic [NPIN-1:0]       RST_PIN  = 7'h00;
   localparam logic [NPIN*SEL_W-1:0] RST_SEL  = 21'h000000;
   localparam logic [1:0]            RST_IRQ  = 2'h0;
   localparam int                    ST_EXT   = 0;
   localparam int                    ST_WAKE  = 1;
   localparam logic [SEL_W-1:0]      SEL_GPIO = 3'h0;
   localparam logic [SEL_W-1:0]      SEL_F1   = 3'h1;
   localparam logic [SEL_W-1:0]      SEL_F2   = 3'h2;
   localparam logic [SEL_W-1:0]      SEL_F3   = 3'h3;
   localparam logic [SEL_W-1:0]      SEL_F4   = 3'h4;
   localparam logic [1:0]            RESP_OK  = 2'h0;
   localparam logic [1:0]            RESP_ERR = 2'h2;

endpackage

// *** verilog/ppfm_pin_cell.sv ***
// Purpose: One port pin: input filter, edge detect, output drive
// Assumes: pad_in_i is asynchronous to clk_i
// Notes:   Output, enable and pull are registered

module ppfm_pin_cell (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Pad side
   input  wire logic pad_in_i,
   output logic      pad_out_o,
   output logic      pad_oe_o,
   output logic      pad_pull_o,
   // Control
   input  wire logic gp_data_i,
   input  wire logic gp_dir_i,
   input  wire logic pull_i,
   input  wire logic die_i,
   input  wire logic alt_en_i,
   input  wire logic alt_val_i,
   input  wire logic ana_i,
   // Sensed input
   output logic      din_o,
   output logic      chg_o
);

   logic s1_r, s2_r, s3_r, fil_r, chg_r, out_r, oe_r, pull_r;
   logic s1_nxt, s2_nxt, s3_nxt, fil_nxt, chg_nxt, out_nxt, oe_nxt, pull_nxt;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s1_nxt   = pad_in_i;
      s2_nxt   = s1_r;
      s3_nxt   = s2_r;
      // A level counts once the second and third stages agree
      fil_nxt  = (s2_r == s3_r) ? s3_r : fil_r;
      // Disabled input raises no edge, and so no wake or interrupt
      chg_nxt  = die_i && (s2_r == s3_r) && (s3_r != fil_r);
      // Peripheral output wins over the general-purpose data
      out_nxt  = alt_en_i ? alt_val_i : gp_data_i;
      oe_nxt   = alt_en_i | (gp_dir_i & ~ana_i);
      pull_nxt = pull_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r   <= 1'b0;
         s2_r   <= 1'b0;
         s3_r   <= 1'b0;
         fil_r  <= 1'b0;
         chg_r  <= 1'b0;
         out_r  <= 1'b0;
         oe_r   <= 1'b0;
         pull_r <= 1'b0;
      end else begin
         s1_r   <= s1_nxt;
         s2_r   <= s2_nxt;
         s3_r   <= s3_nxt;
         fil_r  <= fil_nxt;
         chg_r  <= chg_nxt;
         out_r  <= out_nxt;
         oe_r   <= oe_nxt;
         pull_r <= pull_nxt;
      end
   end

   assign pad_out_o  = out_r;
   assign pad_oe_o   = oe_r;
   assign pad_pull_o = pull_r;
   assign din_o      = fil_r & die_i;
   assign chg_o      = chg_r;

endmodule

// *** verilog/ppfm_top.sv ***
// Purpose: Pin function mux for port A bits 0,3 and port B bits 3..7
// Assumes: One clock, synchronous active-high reset, AXI4-Lite slave
// Notes:   Pin slot order PA0 PA3 PB3 PB4 PB5 PB6 PB7 in all vectors
//
// Summary of operation
// - Each pin is input or push-pull output, with its own pull-up enable.
// - Any wake-enabled pin changing during sleep wakes the system.
// - Input-enable bit 0 disables the pin's digital input and its wake-up.
// - Port A bit 0 is external interrupt zero on both edges.
// - PA0 may drive comparator output, wide PWM zero or LCD common.
// - PA3 may carry comparator input one, timer A PWM, LCD common, PWM two.
// - PB7 may carry comparator input three, timer B PWM, wide PWM one.
// - PB6 may carry comparator input two, timer B PWM, wide PWM one.
// - PB4 may output timer A PWM or wide PWM zero.

module ppfm_top
   import ppfm_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // AXI4-Lite write
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [ppfm_pkg::AW-1:0] s_axi_awaddr,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   output logic [1:0]                s_axi_bresp,
   // AXI4-Lite read
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   input  wire logic [ppfm_pkg::AW-1:0] s_axi_araddr,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   // Pads
   input  wire logic [ppfm_pkg::NPIN-1:0] pad_in_i,
   output logic [ppfm_pkg::NPIN-1:0] pad_out_o,
   output logic [ppfm_pkg::NPIN-1:0] pad_oe_o,
   output logic [ppfm_pkg::NPIN-1:0] pad_pull_o,
   // Peripheral outputs to route
   input  wire logic                 comparator_out_i,
   input  wire logic                 timer_a_pwm_out_i,
   input  wire logic                 timer_b_pwm_out_i,
   input  wire logic                 wide_pwm_zero_out_i,
   input  wire logic                 wide_pwm_one_out_i,
   input  wire logic                 wide_pwm_two_out_i,
   input  wire logic                 lcd_common_b_i,
   input  wire logic                 lcd_common_d_i,
   // Analogue routing and events
   output logic                      comparator_neg_in_one_o,
   output logic                      comparator_neg_in_two_o,
   output logic                      comparator_neg_in_three_o,
   input  wire logic                 sleep_i,
   output logic                      wake_o,
   output logic                      ext_irq_line_zero_o,
   output logic                      irq_o
);
   import ppfm_pkg::*;

   logic              aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [AW-1:0]     aw_addr_r, aw_addr_nxt;
   logic [31:0]       w_data_r, w_data_nxt;
   logic [3:0]        w_strb_r, w_strb_nxt;
   logic              awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, ardy_r, ardy_nxt;
   logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0]       rdata_r, rdata_nxt, wv;
   logic [NPIN-1:0]   data_r, data_nxt, dir_r, dir_nxt, pull_r, pull_nxt;
   logic [NPIN-1:0]   die_r, die_nxt, wken_r, wken_nxt;
   logic [NPIN*SEL_W-1:0] sel_r, sel_nxt;
   logic [1:0]        stat_r, stat_nxt, mask_r, mask_nxt, ev, clr;
   logic              irq_r, irq_nxt, ext_r, ext_nxt, wake_r, wake_nxt;
   logic [2:0]        neg_r, neg_nxt;
   logic [NPIN-1:0]   alt_en, alt_val, ana, din, chg;
   logic              aw_hs, w_hs, ar_hs;

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Alternate function decode
   // ----------------------------------------------------------------
   // Unlisted select codes fall back to general-purpose use
   always_comb begin
      alt_en  = '0;
      alt_val = '0;
      ana     = '0;
      case (sel_r[SEL_W*P_PA0 +: SEL_W])
         SEL_F1: begin alt_en[P_PA0] = 1'b1; alt_val[P_PA0] = comparator_out_i; end
         SEL_F2: begin alt_en[P_PA0] = 1'b1; alt_val[P_PA0] = wide_pwm_zero_out_i; end
         SEL_F3: begin alt_en[P_PA0] = 1'b1; alt_val[P_PA0] = lcd_common_b_i; end
         default: ;
      endcase
      case (sel_r[SEL_W*P_PA3 +: SEL_W])
         SEL_F1: ana[P_PA3] = 1'b1;
         SEL_F2: begin alt_en[P_PA3] = 1'b1; alt_val[P_PA3] = timer_a_pwm_out_i; end
         SEL_F3: begin alt_en[P_PA3] = 1'b1; alt_val[P_PA3] = lcd_common_d_i; end
         SEL_F4: begin alt_en[P_PA3] = 1'b1; alt_val[P_PA3] = wide_pwm_two_out_i; end
         default: ;
      endcase
      case (sel_r[SEL_W*P_PB3 +: SEL_W])
         SEL_F1: begin alt_en[P_PB3] = 1'b1; alt_val[P_PB3] = wide_pwm_two_out_i; end
         default: ;
      endcase
      case (sel_r[SEL_W*P_PB4 +: SEL_W])
         SEL_F1: begin alt_en[P_PB4] = 1'b1; alt_val[P_PB4] = timer_a_pwm_out_i; end
         SEL_F2: begin alt_en[P_PB4] = 1'b1; alt_val[P_PB4] = wide_pwm_zero_out_i; end
         default: ;
      endcase
      case (sel_r[SEL_W*P_PB5 +: SEL_W])
         SEL_F1: begin alt_en[P_PB5] = 1'b1; alt_val[P_PB5] = timer_b_pwm_out_i; end
         SEL_F2: begin alt_en[P_PB5] = 1'b1; alt_val[P_PB5] = wide_pwm_zero_out_i; end
         default: ;
      endcase
      case (sel_r[SEL_W*P_PB6 +: SEL_W])
         SEL_F1: ana[P_PB6] = 1'b1;
         SEL_F2: begin alt_en[P_PB6] = 1'b1; alt_val[P_PB6] = timer_b_pwm_out_i; end
         SEL_F3: begin alt_en[P_PB6] = 1'b1; alt_val[P_PB6] = wide_pwm_one_out_i; end
         default: ;
      endcase
      case (sel_r[SEL_W*P_PB7 +: SEL_W])
         SEL_F1: ana[P_PB7] = 1'b1;
         SEL_F2: begin alt_en[P_PB7] = 1'b1; alt_val[P_PB7] = timer_b_pwm_out_i; end
         SEL_F3: begin alt_en[P_PB7] = 1'b1; alt_val[P_PB7] = wide_pwm_one_out_i; end
         default: ;
      endcase
   end

   // ----------------------------------------------------------------
   // Pin cells
   // ----------------------------------------------------------------
   for (genvar k = 0; k < NPIN; k++) begin : g_pin
      ppfm_pin_cell u_cell (
         .clk_i      (clk_i),
         .rst_i      (rst_i),
         .pad_in_i   (pad_in_i[k]),
         .pad_out_o  (pad_out_o[k]),
         .pad_oe_o   (pad_oe_o[k]),
         .pad_pull_o (pad_pull_o[k]),
         .gp_data_i  (data_r[k]),
         .gp_dir_i   (dir_r[k]),
         .pull_i     (pull_r[k]),
         .die_i      (die_r[k]),
         .alt_en_i   (alt_en[k]),
         .alt_val_i  (alt_val[k]),
         .ana_i      (ana[k]),
         .din_o      (din[k]),
         .chg_o      (chg[k])
      );
   end

   // ----------------------------------------------------------------
   // Bus slave, registers, events
   // ----------------------------------------------------------------
   assign aw_hs = s_axi_awvalid & awrdy_r;
   assign w_hs  = s_axi_wvalid & wrdy_r;
   assign ar_hs = s_axi_arvalid & ardy_r;

   always_comb begin
      aw_hold_nxt = aw_hold_r;
      aw_addr_nxt = aw_addr_r;
      w_hold_nxt  = w_hold_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r & ~s_axi_bready;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r & ~s_axi_rready;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      data_nxt    = data_r;
      dir_nxt     = dir_r;
      pull_nxt    = pull_r;
      die_nxt     = die_r;
      wken_nxt    = wken_r;
      sel_nxt     = sel_r;
      mask_nxt    = mask_r;
      clr         = 2'h0;
      wv          = 32'h0;
      if (aw_hs) begin
         aw_hold_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (w_hs) begin
         w_hold_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      // Both halves held: commit one cycle later, answering at the same edge
      if (aw_hold_r && w_hold_r && !bvalid_r) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = RESP_OK;
         if (aw_addr_r == A_DATA) begin
            data_nxt = NPIN'(wmerge({25'h0, data_r}, w_data_r, w_strb_r));
         end else if (aw_addr_r == A_DIR) begin
            dir_nxt = NPIN'(wmerge({25'h0, dir_r}, w_data_r, w_strb_r));
         end else if (aw_addr_r == A_PULL) begin
            pull_nxt = NPIN'(wmerge({25'h0, pull_r}, w_data_r, w_strb_r));
         end else if (aw_addr_r == A_DIE) begin
            die_nxt = NPIN'(wmerge({25'h0, die_r}, w_data_r, w_strb_r));
         end else if (aw_addr_r == A_WAKE) begin
            wken_nxt = NPIN'(wmerge({25'h0, wken_r}, w_data_r, w_strb_r));
         end else if (aw_addr_r == A_SEL) begin
            sel_nxt = (NPIN*SEL_W)'(wmerge({11'h0, sel_r}, w_data_r, w_strb_r));
         end else if (aw_addr_r == A_MASK) begin
            mask_nxt = 2'(wmerge({30'h0, mask_r}, w_data_r, w_strb_r));
         end else if (aw_addr_r == A_IN || aw_addr_r == A_STAT) begin
            // Read-only registers ignore writes
            bresp_nxt = RESP_OK;
         end else begin
            bresp_nxt = RESP_ERR;
         end
      end
      if (ar_hs) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OK;
         if (s_axi_araddr == A_DATA) begin
            wv[NPIN-1:0] = data_r;
         end else if (s_axi_araddr == A_DIR) begin
            wv[NPIN-1:0] = dir_r;
         end else if (s_axi_araddr == A_PULL) begin
            wv[NPIN-1:0] = pull_r;
         end else if (s_axi_araddr == A_DIE) begin
            wv[NPIN-1:0] = die_r;
         end else if (s_axi_araddr == A_WAKE) begin
            wv[NPIN-1:0] = wken_r;
         end else if (s_axi_araddr == A_IN) begin
            wv[NPIN-1:0] = din;
         end else if (s_axi_araddr == A_SEL) begin
            wv[NPIN*SEL_W-1:0] = sel_r;
         end else if (s_axi_araddr == A_STAT) begin
            wv[1:0] = stat_r;
            clr     = 2'h3;
         end else if (s_axi_araddr == A_MASK) begin
            wv[1:0] = mask_r;
         end else begin
            rresp_nxt = RESP_ERR;
         end
         rdata_nxt = wv;
      end
      awrdy_nxt = ~aw_hold_nxt & ~bvalid_nxt;
      wrdy_nxt  = ~w_hold_nxt & ~bvalid_nxt;
      ardy_nxt  = ~rvalid_nxt;
      // Events; a new event wins over a read-clear in the same cycle
      ev[ST_EXT]  = chg[P_PA0];
      ev[ST_WAKE] = sleep_i & |(chg & wken_r);
      stat_nxt    = (stat_r & ~clr) | ev;
      irq_nxt     = |(stat_nxt & mask_nxt);
      ext_nxt     = ev[ST_EXT];
      wake_nxt    = ev[ST_WAKE];
      neg_nxt     = {ana[P_PB7], ana[P_PB6], ana[P_PA3]};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= '0;
         w_hold_r  <= 1'b0;
         w_data_r  <= 32'h0;
         w_strb_r  <= 4'h0;
         awrdy_r   <= 1'b0;
         wrdy_r    <= 1'b0;
         ardy_r    <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OK;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OK;
         rdata_r   <= 32'h0;
         data_r    <= RST_PIN;
         dir_r     <= RST_PIN;
         pull_r    <= RST_PIN;
         die_r     <= RST_PIN;
         wken_r    <= RST_PIN;
         sel_r     <= RST_SEL;
         stat_r    <= RST_IRQ;
         mask_r    <= RST_IRQ;
         irq_r     <= 1'b0;
         ext_r     <= 1'b0;
         wake_r    <= 1'b0;
         neg_r     <= 3'h0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_hold_r  <= w_hold_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         awrdy_r   <= awrdy_nxt;
         wrdy_r    <= wrdy_nxt;
         ardy_r    <= ardy_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
         data_r    <= data_nxt;
         dir_r     <= dir_nxt;
         pull_r    <= pull_nxt;
         die_r     <= die_nxt;
         wken_r    <= wken_nxt;
         sel_r     <= sel_nxt;
         stat_r    <= stat_nxt;
         mask_r    <= mask_nxt;
         irq_r     <= irq_nxt;
         ext_r     <= ext_nxt;
         wake_r    <= wake_nxt;
         neg_r     <= neg_nxt;
      end
   end

   assign s_axi_awready             = awrdy_r;
   assign s_axi_wready              = wrdy_r;
   assign s_axi_bvalid              = bvalid_r;
   assign s_axi_bresp               = bresp_r;
   assign s_axi_arready             = ardy_r;
   assign s_axi_rvalid              = rvalid_r;
   assign s_axi_rdata               = rdata_r;
   assign s_axi_rresp               = rresp_r;
   assign irq_o                     = irq_r;
   assign ext_irq_line_zero_o       = ext_r;
   assign wake_o                    = wake_r;
   assign comparator_neg_in_one_o   = neg_r[0];
   assign comparator_neg_in_two_o   = neg_r[1];
   assign comparator_neg_in_three_o = neg_r[2];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_gpio_drive: assert property (
      dir_r[P_PB4] && sel_r[SEL_W*P_PB4 +: SEL_W] == SEL_GPIO
      |=> pad_oe_o[P_PB4] && pad_out_o[P_PB4] == $past(data_r[P_PB4]))
      else $error("gpio output not driven from data");
   a_wake_sleep: assert property (
      wake_o |-> $past(sleep_i) && stat_r[ST_WAKE])
      else $error("wake without sleep or status");
   a_die_block: assert property (
      !die_r[P_PA0] [*2] |=> !ext_irq_line_zero_o)
      else $error("edge seen on disabled input");
   a_ext_status: assert property (
      ext_irq_line_zero_o |-> stat_r[ST_EXT] && $past(din[P_PA0], 2) != $past(din[P_PA0]))
      else $error("ext irq without edge or status");
   a_pa0_pwm: assert property (
      sel_r[SEL_W*P_PA0 +: SEL_W] == SEL_F2
      |=> pad_oe_o[P_PA0] && pad_out_o[P_PA0] == $past(wide_pwm_zero_out_i))
      else $error("pa0 not carrying wide pwm zero");
   a_pa3_analog: assert property (
      sel_r[SEL_W*P_PA3 +: SEL_W] == SEL_F1
      |=> !pad_oe_o[P_PA3] && comparator_neg_in_one_o)
      else $error("pa3 analogue mode wrong");
   a_pb7_analog: assert property (
      sel_r[SEL_W*P_PB7 +: SEL_W] == SEL_F1 [*2] |=> comparator_neg_in_three_o)
      else $error("pb7 comparator input not routed");
   a_pb6_pwm: assert property (
      sel_r[SEL_W*P_PB6 +: SEL_W] == SEL_F3
      |=> pad_out_o[P_PB6] == $past(wide_pwm_one_out_i))
      else $error("pb6 not carrying wide pwm one");
   a_pb5_timer: assert property (
      sel_r[SEL_W*P_PB5 +: SEL_W] == SEL_F1
      |=> pad_out_o[P_PB5] == $past(timer_b_pwm_out_i))
      else $error("pb5 not carrying timer b pwm");
   a_pb3_pwm: assert property (
      sel_r[SEL_W*P_PB3 +: SEL_W] == SEL_F1
      |=> pad_oe_o[P_PB3] && pad_out_o[P_PB3] == $past(wide_pwm_two_out_i))
      else $error("pb3 not carrying wide pwm two");
   a_alt_priority: assert property (
      sel_r[SEL_W*P_PB4 +: SEL_W] == SEL_F1 && data_r[P_PB4] != timer_a_pwm_out_i
      |=> pad_out_o[P_PB4] != $past(data_r[P_PB4]))
      else $error("gpio data beat peripheral output");

endmodule

// *** testbench/ppfm_board.sv ***
// Purpose: Board circuitry seen by the port pins
// Assumes: A driving pad wins over the board source
// Notes:   A released pin with pull-up reads high, else the board source
module ppfm_board
   import ppfm_pkg::*;
(
   // Pad side
   input  wire logic [ppfm_pkg::NPIN-1:0] out_i,
   input  wire logic [ppfm_pkg::NPIN-1:0] oe_i,
   input  wire logic [ppfm_pkg::NPIN-1:0] pull_i,
   // Board side
   input  wire logic [ppfm_pkg::NPIN-1:0] ext_i,
   output logic      [ppfm_pkg::NPIN-1:0] pad_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      for (int k = 0; k < NPIN; k++) begin
         pad_o[k] = oe_i[k] ? out_i[k] : (pull_i[k] ? 1'b1 : ext_i[k]);
      end
   end
endmodule

// *** testbench/tb_port_pin_function_mux.sv ***
// Purpose: Self-checking bench of the port pin function mux
// Assumes: Registers over AXI4-Lite, pins resolved by the board model
// Notes:   Random stimulus from a fixed seed
module tb_port_pin_function_mux import ppfm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, sleep = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, per = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [6:0]  ext = 7'h00, pad, pout, poe, ppull;
   logic        awready, wready, bvalid, arready, rvalid, wake, xirq, irq;
   logic [1:0]  bresp, rresp;
   logic [2:0]  ana;
   int          fails = 0, total_checks = 0, seed = 32'hcc31;
   localparam int MAP [7][5] = '{'{8,0,3,6,8}, '{8,9,1,7,5}, '{8,5,8,8,8}, '{8,1,3,8,8},
                                 '{8,2,3,8,8}, '{8,9,2,4,8}, '{8,9,2,4,8}};
   ppfm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awvalid(awv), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .pad_in_i(pad), .pad_out_o(pout), .pad_oe_o(poe), .pad_pull_o(ppull),
      .comparator_out_i(per[0]), .timer_a_pwm_out_i(per[1]), .timer_b_pwm_out_i(per[2]),
      .wide_pwm_zero_out_i(per[3]), .wide_pwm_one_out_i(per[4]), .wide_pwm_two_out_i(per[5]),
      .lcd_common_b_i(per[6]), .lcd_common_d_i(per[7]), .comparator_neg_in_one_o(ana[0]),
      .comparator_neg_in_two_o(ana[1]), .comparator_neg_in_three_o(ana[2]), .sleep_i(sleep),
      .wake_o(wake), .ext_irq_line_zero_o(xirq), .irq_o(irq));
   ppfm_board board (.out_i(pout), .oe_i(poe), .pull_i(ppull), .ext_i(ext), .pad_o(pad));
   initial forever #2.5 clk_i = ~clk_i;
   // Expected {oe, driven value} of one pin
   function automatic logic [1:0] exp_pin(int k, int c, logic [6:0] dr, dt, logic [7:0] p);
      int m;
      m = MAP[k][c];
      if (m < 8) return {1'b1, p[m]};
      if (m == 9) return 2'b00;
      return {dr[k], dr[k] & dt[k]};
   endfunction
   task automatic chk(input logic [63:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (awv && awready) awv <= 1'b0;
         if (wv && wready) wv <= 1'b0;
         if (bvalid) break;
      end
      // Ready stays high so a following call never re-drives it in the same step
      chk(bresp, RESP_OK);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (arv && arready) arv <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
   endtask
   // Count event pulses over a span longer than the input filter delay
   task automatic pulses(output int nx, nw);
      nx = 0;
      nw = 0;
      repeat (10) begin
         @(posedge clk_i);
         #1;
         nx += (xirq === 1'b1);
         nw += (wake === 1'b1);
      end
      @(posedge clk_i);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      test_done();
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [6:0]  dr, dt, pl;
      int          nx, nw;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rd(A_DIE, d, r);
      chk(d, 0);
      rd(8'hfc, d, r);
      chk({d, r}, {32'h0, RESP_ERR});
      $display("test reset done");
      wr(A_DIE, 0);
      for (int k = 0; k < NPIN; k++) begin
         for (int c = 0; c < 5; c++) begin
            dr = 7'($random(seed));
            dt = 7'($random(seed));
            pl = 7'($random(seed));
            per <= 8'($random(seed));
            wr(A_DIR, 32'(dr));
            wr(A_DATA, 32'(dt));
            wr(A_PULL, 32'(pl));
            wr(A_SEL, 32'(c) << (3 * k));
            repeat (3) @(posedge clk_i);
            #1;
            chk({poe[k], poe[k] & pout[k]}, exp_pin(k, c, dr, dt, per));
            chk(ana, {k == 6, k == 5, k == 1} & {3{MAP[k][c] == 9}});
            chk(ppull, pl);
            @(posedge clk_i);
         end
      end
      $display("test mux done");
      wr(A_SEL, 0);
      wr(A_DIR, 0);
      wr(A_PULL, 0);
      wr(A_MASK, 3);
      wr(A_DIE, 1);
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 2; i++) begin
         ext[0] <= ~ext[0];
         pulses(nx, nw);
         chk(nx, 1);
         chk(irq, 1);
         rd(A_STAT, d, r);
         chk(d, 1);
         repeat (2) @(posedge clk_i);
         chk(irq, 0);
      end
      wr(A_DIE, 0);
      ext[0] <= ~ext[0];
      pulses(nx, nw);
      chk(nx, 0);
      $display("test edge done");
      sleep <= 1'b1;
      wr(A_WAKE, 32'h7f);
      wr(A_DIE, 32'h10);
      repeat (8) @(posedge clk_i);
      ext[4] <= 1'b1;
      pulses(nx, nw);
      chk(nw, 1);
      ext[3] <= 1'b1;
      pulses(nx, nw);
      chk(nw, 0);
      rd(A_IN, d, r);
      chk(d, 32'h10);
      $display("test wake done");
      test_done();
   end
endmodule
